// ### rtl/flash_host.sv
// Flash host controller: APB registers, command cycles, status polling
`timescale 1ns/1ps
module flash_host
	import flash_host_pkg::*;
#(
	parameter int PROTECT_CYC = PROT_CYC,
	parameter int LEN_W       = 16
)
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	// Flash strobes and address
	output logic                   ce_n,
	output logic                   we_n,
	output logic                   oe_n,
	output logic [ADDR_W-1:0]      flash_addr,
	// Flash data, two-way
	input  wire logic [7:0]        dq_in,
	output logic [7:0]             dq_out,
	output logic                   dq_oe,
	// High-voltage qualifiers
	output logic                   reset_hv,
	output logic                   a9_hv,
	output logic                   oe_hv,
	// Device ready pin
	input  wire logic              ready_busy_n
);
	typedef enum logic [3:0] {
		S_IDLE   = 4'h0,
		S_PREAD  = 4'h1,
		S_PEVAL  = 4'h3,
		S_RST    = 4'h2,
		S_CYC    = 4'h6,
		S_AREAD1 = 4'h7,
		S_AWRITE = 4'h5,
		S_AREAD2 = 4'h4
	} host_state_t;

	typedef struct packed {
		host_state_t       st;
		op_t               op;
		logic              iss;
		logic              start;
		logic              clr;
		logic              recheck;
		logic              temp_unprot;
		logic              in_sys;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              ok;
		logic              fail;
		logic              reject;
		logic              maybe;
		logic [7:0]        rd;
		logic              rb_n;
		logic              a9_hv;
		logic              oe_hv;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} host_t;

	host_t             s;
	host_t             next_s;
	logic              cyc_done;
	logic [7:0]        cyc_rdata;
	logic              cyc_write;
	logic [ADDR_W-1:0] cyc_addr;
	logic [7:0]        cyc_wdata;
	logic [LEN_W-1:0]  cyc_len;
	logic              tog_pair;
	logic              tog_one;
	logic              tog_two;
	logic [31:0]       ctrl_rd;
	logic [31:0]       stat_rd;
	op_t               new_op;

	// Register read images
	always_comb
	begin
		ctrl_rd = '0;
		ctrl_rd[CTRL_OP_W-1:0] = s.op;
		ctrl_rd[CTRL_TU_BIT] = s.temp_unprot;
		ctrl_rd[CTRL_INSYS_BIT] = s.in_sys;
		stat_rd = '0;
		stat_rd[ST_BUSY] = (s.st != S_IDLE);
		stat_rd[ST_OK] = s.ok;
		stat_rd[ST_FAIL] = s.fail;
		stat_rd[ST_REJECT] = s.reject;
		stat_rd[ST_MAYBE] = s.maybe;
		stat_rd[ST_RB] = s.rb_n;
		stat_rd[ST_RD_LSB +: 8] = s.rd;
		new_op = op_t'(pwdata[CTRL_OP_W-1:0]);
	end

	// Cycle request follows the state; the pin module latches it at start, and len one cycle later
	always_comb
	begin
		cyc_write = 1'b0;
		cyc_addr = s.addr;
		cyc_wdata = s.wdata;
		cyc_len = LEN_W'(READ_CYC);
		case (s.st)
			S_RST:
			begin
				cyc_write = 1'b1;
				cyc_wdata = RESET_CMD;
				cyc_len = LEN_W'(STROBE_CYC);
			end
			S_AWRITE:
			begin
				cyc_write = 1'b1;
				cyc_wdata = ERASE_CONFIRM;
				cyc_len = LEN_W'(STROBE_CYC);
			end
			S_CYC:
				case (s.op)
					OP_WRITE:
					begin
						cyc_write = 1'b1;
						cyc_len = LEN_W'(STROBE_CYC);
					end
					OP_PROTECT:
					begin
						cyc_write = 1'b1;
						cyc_len = LEN_W'(PROTECT_CYC);
					end
					OP_UNPROTECT:
					begin
						cyc_write = 1'b1;
						cyc_addr[A6_BIT] = 1'b1;
						cyc_len = LEN_W'(PROTECT_CYC);
					end
					OP_VERIFY:
					begin
						cyc_addr[A1_BIT] = 1'b1;
						cyc_addr[A0_BIT] = 1'b0;
						cyc_addr[A6_BIT] = 1'b0;
					end
					default:
						cyc_len = LEN_W'(READ_CYC);
				endcase
			default:
				cyc_len = LEN_W'(READ_CYC);
		endcase
	end

	// Sequencer and APB slave
	always_comb
	begin
		next_s = s;
		next_s.start = 1'b0;
		next_s.clr = 1'b0;
		next_s.rb_n = ready_busy_n;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		// Each busy state except S_PEVAL issues exactly one pin cycle
		if (s.st != S_IDLE && s.st != S_PEVAL && !s.iss)
		begin
			next_s.iss = 1'b1;
			next_s.start = 1'b1;
		end
		case (s.st)
			S_CYC:
				if (cyc_done)
				begin
					next_s.iss = 1'b0;
					next_s.rd = cyc_rdata;
					next_s.ok = 1'b1;
					next_s.a9_hv = 1'b0;
					next_s.oe_hv = 1'b0;
					next_s.st = S_IDLE;
				end
			S_PREAD:
				if (cyc_done)
				begin
					next_s.iss = 1'b0;
					next_s.rd = cyc_rdata;
					next_s.st = S_PEVAL;
				end
			S_PEVAL:
				// Toggle stopped means done; timeout needs one more fresh pair
				if (!tog_pair)
					next_s.st = S_PREAD;
				else if (!tog_one)
				begin
					next_s.ok = 1'b1;
					next_s.st = S_IDLE;
				end
				else if (s.rd[TMO_BIT] && !s.recheck)
				begin
					next_s.recheck = 1'b1;
					next_s.clr = 1'b1;
					next_s.st = S_PREAD;
				end
				else if (s.rd[TMO_BIT])
				begin
					next_s.fail = 1'b1;
					next_s.st = S_RST;
				end
				else
					next_s.st = S_PREAD;
			S_RST:
				if (cyc_done)
				begin
					next_s.iss = 1'b0;
					next_s.st = S_IDLE;
				end
			S_AREAD1:
				if (cyc_done)
				begin
					next_s.iss = 1'b0;
					next_s.rd = cyc_rdata;
					// Window already closed: the command would be ignored
					if (cyc_rdata[EW_BIT])
					begin
						next_s.reject = 1'b1;
						next_s.st = S_IDLE;
					end
					else
						next_s.st = S_AWRITE;
				end
			S_AWRITE:
				if (cyc_done)
				begin
					next_s.iss = 1'b0;
					next_s.st = S_AREAD2;
				end
			S_AREAD2:
				if (cyc_done)
				begin
					next_s.iss = 1'b0;
					next_s.rd = cyc_rdata;
					next_s.maybe = cyc_rdata[EW_BIT];
					next_s.ok = !cyc_rdata[EW_BIT];
					next_s.st = S_IDLE;
				end
			default:
				next_s.iss = 1'b0;
		endcase
		// Answer one cycle into the access phase
		if (psel && penable && !s.pready)
		begin
			next_s.pready = 1'b1;
			next_s.prdata = '0;
			if (paddr == REG_CTRL)
				next_s.prdata = ctrl_rd;
			else if (paddr == REG_ADDR)
				next_s.prdata[ADDR_W-1:0] = s.addr;
			else if (paddr == REG_WDATA)
				next_s.prdata[7:0] = s.wdata;
			else if (paddr == REG_STATUS)
				next_s.prdata = stat_rd;
			else
				next_s.pslverr = 1'b1;
		end
		// Writes land at the edge where pready is sampled high
		if (psel && penable && s.pready && pwrite)
		begin
			if (paddr == REG_CTRL)
			begin
				next_s.temp_unprot = pwdata[CTRL_TU_BIT];
				next_s.in_sys = pwdata[CTRL_INSYS_BIT];
				// A new op while busy is dropped, not queued
				if (s.st == S_IDLE && new_op != OP_NONE)
				begin
					next_s.op = new_op;
					next_s.ok = 1'b0;
					next_s.fail = 1'b0;
					next_s.reject = 1'b0;
					next_s.maybe = 1'b0;
					next_s.recheck = 1'b0;
					next_s.clr = 1'b1;
					next_s.iss = 1'b0;
					next_s.a9_hv = (new_op == OP_PROTECT) || (new_op == OP_UNPROTECT) ||
						((new_op == OP_VERIFY) && !pwdata[CTRL_INSYS_BIT]);
					next_s.oe_hv = (new_op == OP_PROTECT) || (new_op == OP_UNPROTECT);
					if (new_op == OP_POLL)
						next_s.st = S_PREAD;
					else if (new_op == OP_ADDSEC)
						next_s.st = S_AREAD1;
					else
						next_s.st = S_CYC;
				end
			end
			else if (paddr == REG_ADDR)
				next_s.addr = pwdata[ADDR_W-1:0];
			else if (paddr == REG_WDATA)
				next_s.wdata = pwdata[7:0];
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	// Pin cycle engine
	flash_pin_cycle #(
		.LEN_W (LEN_W)
	) u_cycle (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.start      (s.start),
		.is_write   (cyc_write),
		.addr       (cyc_addr),
		.wdata      (cyc_wdata),
		.len        (cyc_len),
		.done       (cyc_done),
		.rdata      (cyc_rdata),
		.ce_n       (ce_n),
		.we_n       (we_n),
		.oe_n       (oe_n),
		.flash_addr (flash_addr),
		.dq_out     (dq_out),
		.dq_oe      (dq_oe),
		.dq_in      (dq_in)
	);

	// Toggle detector fed by each S_PREAD status read
	flash_toggle_check u_toggle (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.clear       (s.clr),
		.valid       (cyc_done && s.st == S_PREAD),
		.data        (cyc_rdata),
		.pair        (tog_pair),
		.toggled_one (tog_one),
		.toggled_two (tog_two)
	);

	assign pready = s.pready;
	assign prdata = s.prdata;
	assign pslverr = s.pslverr;
	assign reset_hv = s.temp_unprot;
	assign a9_hv = s.a9_hv;
	assign oe_hv = s.oe_hv;

	// Checks on the pins this controller drives
	property p_write_qual;
		@(posedge clk_sys) disable iff (rst) (!we_n && !ce_n) |-> oe_n;
	endproperty
	a_write_qual: assert property (p_write_qual) else $error("write with oe low");

	property p_reset_after_timeout;
		@(posedge clk_sys) disable iff (rst)
			$rose(s.fail) |-> ##[1:4] (!we_n && dq_oe && dq_out == RESET_CMD);
	endproperty
	a_reset_after_timeout: assert property (p_reset_after_timeout)
		else $error("no reset command after timeout");

	property p_poll_addr;
		@(posedge clk_sys) disable iff (rst)
			(s.st == S_PREAD && !oe_n) |-> (flash_addr == s.addr);
	endproperty
	a_poll_addr: assert property (p_poll_addr) else $error("poll at wrong address");

	property p_addsec_checked;
		@(posedge clk_sys) disable iff (rst)
			(s.st == S_AWRITE && !we_n) |-> (!s.rd[EW_BIT] && $past(s.st, 3) != S_IDLE);
	endproperty
	a_addsec_checked: assert property (p_addsec_checked)
		else $error("sector added without window check");

	property p_verify_addr;
		@(posedge clk_sys) disable iff (rst)
			(s.op == OP_VERIFY && s.st == S_CYC && !oe_n) |->
			(flash_addr[A1_BIT] && !flash_addr[A0_BIT] && (a9_hv == !s.in_sys));
	endproperty
	a_verify_addr: assert property (p_verify_addr) else $error("bad verify address");

	c_poll_ok: cover property (@(posedge clk_sys) disable iff (rst)
		(s.st == S_PEVAL) ##1 (s.st == S_IDLE && s.ok));
	c_timeout: cover property (@(posedge clk_sys) disable iff (rst) $rose(s.fail));
	c_maybe: cover property (@(posedge clk_sys) disable iff (rst) $rose(s.maybe));
endmodule

// ### rtl/flash_host_pkg.sv
// Constants, register map and types for the flash host controller
package flash_host_pkg;
	// Clock and timing, figures in ns or us, counts derived
	localparam int CLK_NS     = 4;
	localparam int GLITCH_NS  = 5;
	localparam int STROBE_NS  = 40;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_NS     = 90;
	localparam int READ_CYC   = (ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_NS    = 10;
	localparam int HOLD_CYC   = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROT_US    = 100;
	localparam int PROT_CYC   = (PROT_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int ADDR_W     = 20;

	// Register byte offsets on APB
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_ADDR   = 12'h004;
	localparam logic [11:0] REG_WDATA  = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00c;

	// Control register fields
	localparam int CTRL_OP_W     = 3;
	localparam int CTRL_TU_BIT   = 8;
	localparam int CTRL_INSYS_BIT = 9;

	// Status register fields
	localparam int ST_BUSY   = 0;
	localparam int ST_OK     = 1;
	localparam int ST_FAIL   = 2;
	localparam int ST_REJECT = 3;
	localparam int ST_MAYBE  = 4;
	localparam int ST_RB     = 5;
	localparam int ST_RD_LSB = 8;

	// Status bits returned by the device on a read
	localparam int POLL_BIT = 7;
	localparam int T1_BIT   = 6;
	localparam int TMO_BIT  = 5;
	localparam int EW_BIT   = 3;
	localparam int T2_BIT   = 2;

	// Address bits used by protection modes
	localparam int A0_BIT = 0;
	localparam int A1_BIT = 1;
	localparam int A6_BIT = 6;

	// Command bytes
	localparam logic [7:0] RESET_CMD     = 8'hf0;
	localparam logic [7:0] ERASE_CONFIRM = 8'h30;

	typedef enum logic [2:0] {
		OP_NONE      = 3'h0,
		OP_WRITE     = 3'h1,
		OP_READ      = 3'h2,
		OP_POLL      = 3'h3,
		OP_ADDSEC    = 3'h4,
		OP_PROTECT   = 3'h5,
		OP_UNPROTECT = 3'h6,
		OP_VERIFY    = 3'h7
	} op_t;
endpackage

// ### rtl/flash_pin_cycle.sv
// One strobed read or write cycle on the flash pins
`timescale 1ns/1ps
module flash_pin_cycle
	import flash_host_pkg::*;
#(
	parameter int LEN_W = 16
)
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// Request
	input  wire logic              start,
	input  wire logic              is_write,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic [LEN_W-1:0]  len,
	output logic                   done,
	output logic [7:0]             rdata,
	// Flash pins
	output logic                   ce_n,
	output logic                   we_n,
	output logic                   oe_n,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [7:0]             dq_out,
	output logic                   dq_oe,
	input  wire logic [7:0]        dq_in
);
	typedef enum logic [1:0] {
		C_IDLE   = 2'b00,
		C_SETUP  = 2'b01,
		C_STROBE = 2'b11,
		C_HOLD   = 2'b10
	} cyc_state_t;

	typedef struct packed {
		cyc_state_t        st;
		logic [LEN_W-1:0]  cnt;
		logic              wr;
		logic              done;
		logic [7:0]        rd;
		logic              ce_n;
		logic              we_n;
		logic              oe_n;
		logic [ADDR_W-1:0] a;
		logic [7:0]        dq;
		logic              dq_oe;
	} cyc_t;

	cyc_t s;
	cyc_t next_s;

	// Oe stays high across a write and we stays high across a read
	always_comb
	begin
		next_s = s;
		next_s.done = 1'b0;
		case (s.st)
			C_IDLE:
				if (start)
				begin
					next_s.a = addr;
					next_s.wr = is_write;
					next_s.dq = wdata;
					next_s.dq_oe = is_write;
					next_s.ce_n = 1'b0;
					next_s.st = C_SETUP;
				end
			C_SETUP:
			begin
				next_s.we_n = !s.wr;
				next_s.oe_n = s.wr;
				next_s.cnt = len;
				next_s.st = C_STROBE;
			end
			C_STROBE:
				if (s.cnt <= LEN_W'(1))
				begin
					// Strobe width far above the device glitch filter
					next_s.we_n = 1'b1;
					next_s.oe_n = 1'b1;
					next_s.ce_n = 1'b1;
					if (!s.wr)
						next_s.rd = dq_in;
					next_s.cnt = LEN_W'(HOLD_CYC);
					next_s.st = C_HOLD;
				end
				else
					next_s.cnt = s.cnt - LEN_W'(1);
			default:
				// Hold data and keep oe high before the next status read
				if (s.cnt <= LEN_W'(1))
				begin
					next_s.dq_oe = 1'b0;
					next_s.done = 1'b1;
					next_s.st = C_IDLE;
				end
				else
					next_s.cnt = s.cnt - LEN_W'(1);
		endcase
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s <= '0;
			s.ce_n <= 1'b1;
			s.we_n <= 1'b1;
			s.oe_n <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign done = s.done;
	assign rdata = s.rd;
	assign ce_n = s.ce_n;
	assign we_n = s.we_n;
	assign oe_n = s.oe_n;
	assign flash_addr = s.a;
	assign dq_out = s.dq;
	assign dq_oe = s.dq_oe;
endmodule

// ### rtl/flash_toggle_check.sv
// Compares two successive status reads for toggling bits
`timescale 1ns/1ps
module flash_toggle_check
	import flash_host_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Read samples
	input  wire logic       clear,
	input  wire logic       valid,
	input  wire logic [7:0] data,
	// Result of the last pair
	output logic            pair,
	output logic            toggled_one,
	output logic            toggled_two
);
	typedef struct packed {
		logic [7:0] prev;
		logic       have;
		logic       pair;
		logic       t1;
		logic       t2;
	} chk_t;

	chk_t s;
	chk_t next_s;

	// One read alone says nothing; a pair is needed to see toggling
	always_comb
	begin
		next_s = s;
		if (clear)
			next_s = '0;
		else if (valid)
		begin
			if (s.have)
			begin
				next_s.t1 = s.prev[T1_BIT] ^ data[T1_BIT];
				next_s.t2 = s.prev[T2_BIT] ^ data[T2_BIT];
				next_s.pair = 1'b1;
			end
			next_s.prev = data;
			next_s.have = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign pair = s.pair;
	assign toggled_one = s.t1;
	assign toggled_two = s.t2;
endmodule

// ### tb/flash_device_model.sv
// Behavioural flash device facing the host controller pins
`timescale 1ns/1ps
module flash_device_model
#(
	parameter int BUSY_READS = 3
)
(
	// Strobes, address and data from the host
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic [19:0] addr,
	input  wire logic [7:0]  din,
	// High-voltage qualifiers
	input  wire logic        reset_hv,
	input  wire logic        a9_hv,
	input  wire logic        oe_hv,
	// Scenario controls from the bench
	input  wire logic        stuck,
	input  wire logic        win_closed,
	// Device outputs
	output logic [7:0]       dq,
	output logic             ready_busy_n
);
	logic [7:0]  mem [16];
	logic [15:0] prot;
	logic [7:0]  pend;
	logic [3:0]  pa;
	logic [7:0]  q;
	logic        busy;
	logic        tgl;
	logic        wr_act;
	int          left;
	realtime     t_fall;

	// Power-up lands in array read mode
	initial
	begin
		foreach (mem[i]) mem[i] = 8'hff;
		prot = 16'h0000;
		busy = 1'b0;
		tgl = 1'b0;
		q = 8'h00;
		pend = 8'h00;
		pa = 4'h0;
		left = 0;
		t_fall = 0;
	end

	assign ready_busy_n = ~busy;
	// Released bus shows the inverse, so a stale byte never passes
	assign dq = (!oe_n && !ce_n) ? q : ~q;

	// Write window: both strobes low with output strobe high
	always @*
		wr_act = !ce_n && !we_n && oe_n;

	always @(posedge wr_act) t_fall = $realtime;

	// Write ends at whichever strobe rises first, so no same-step race
	always @(negedge wr_act)
	begin
		if (($realtime - t_fall) >= 5.0)
		begin
			if (a9_hv && oe_hv)
			begin
				if (addr[6]) prot = 16'h0000;
				else prot[addr[19:16]] = 1'b1;
			end
			else if (din == 8'hf0) busy = 1'b0;
			else if (!busy && din != 8'h30 &&
				(!prot[addr[19:16]] || reset_hv))
			begin
				pend = din;
				pa = addr[3:0];
				busy = 1'b1;
				left = BUSY_READS;
			end
		end
	end

	// Each read cycle picks verify, status or array data
	always @(negedge oe_n)
	begin
		if (a9_hv && !oe_hv)
			q = {7'h00, prot[addr[19:16]]};
		else if (busy)
		begin
			tgl = ~tgl;
			q = {~pend[7], tgl, stuck, 2'b00, 1'b0, pend[1:0]};
			left = left - 1;
			if (left <= 0 && !stuck)
			begin
				mem[pa] = pend;
				busy = 1'b0;
			end
		end
		else if (addr[19:16] == 4'h2)
			q = {4'h0, win_closed, 3'h0};
		else
			q = mem[addr[3:0]];
	end
endmodule

// ### tb/flash_status_and_protection_bench.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module flash_status_and_protection_bench;
	import flash_host_pkg::*;

	typedef struct {
		op_t         op;
		logic [19:0] a;
		logic [7:0]  d;
		logic [1:0]  hi;
		logic        stuck;
		logic        win;
		logic        fail;
		logic        rej;
		logic        rb;
		logic [1:0]  chk;
		logic [7:0]  b;
	} row_t;

	logic              clk_sys;
	logic              rst;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [11:0]       paddr;
	logic [31:0]       pwdata;
	logic              pready;
	logic [31:0]       prdata;
	logic              pslverr;
	logic              ce_n;
	logic              we_n;
	logic              oe_n;
	logic [ADDR_W-1:0] flash_addr;
	logic [7:0]        dq_in;
	logic [7:0]        dq_out;
	logic              dq_oe;
	logic [7:0]        dev_q;
	logic              reset_hv;
	logic              a9_hv;
	logic              oe_hv;
	logic              ready_busy_n;
	logic              stuck;
	logic              win_closed;
	int                failures;
	int                comparisons;
	int                cycles;
	int                wl;
	logic [31:0]       q;
	logic              e;

	// Ordinary cases: op, addr, data, ctrl hi, stuck, window, fail, reject, rb, chk, byte
	row_t rows[17] = '{
		'{OP_WRITE, 20'h00002, 8'h5a, 2'b00, 0, 0, 0, 0, 0, 2'b10, 8'h00},
		'{OP_POLL, 20'h00002, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b10, 8'h00},
		'{OP_READ, 20'h00002, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b01, 8'h5a},
		'{OP_PROTECT, 20'h10000, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b00, 8'h00},
		'{OP_VERIFY, 20'h10000, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b01, 8'h01},
		'{OP_WRITE, 20'h10003, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b10, 8'h00},
		'{OP_READ, 20'h10003, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b01, 8'hff},
		'{OP_WRITE, 20'h10003, 8'h12, 2'b01, 0, 0, 0, 0, 0, 2'b10, 8'h00},
		'{OP_POLL, 20'h10003, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b10, 8'h00},
		'{OP_READ, 20'h10003, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b01, 8'h12},
		'{OP_UNPROTECT, 20'h10000, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b00, 8'h00},
		'{OP_VERIFY, 20'h10000, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b01, 8'h00},
		'{OP_WRITE, 20'h00005, 8'h33, 2'b00, 1, 0, 0, 0, 0, 2'b10, 8'h00},
		'{OP_POLL, 20'h00005, 8'h00, 2'b00, 1, 0, 1, 0, 1, 2'b10, 8'h00},
		'{OP_READ, 20'h00005, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b01, 8'hff},
		'{OP_ADDSEC, 20'h20000, 8'h00, 2'b00, 0, 0, 0, 0, 1, 2'b00, 8'h00},
		'{OP_ADDSEC, 20'h20000, 8'h00, 2'b00, 0, 1, 0, 1, 1, 2'b00, 8'h00}
	};

	flash_host #(
		.PROTECT_CYC (20)
	) dut_u (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.pready       (pready),
		.prdata       (prdata),
		.pslverr      (pslverr),
		.ce_n         (ce_n),
		.we_n         (we_n),
		.oe_n         (oe_n),
		.flash_addr   (flash_addr),
		.dq_in        (dq_in),
		.dq_out       (dq_out),
		.dq_oe        (dq_oe),
		.reset_hv     (reset_hv),
		.a9_hv        (a9_hv),
		.oe_hv        (oe_hv),
		.ready_busy_n (ready_busy_n)
	);

	flash_device_model dev_u (
		.ce_n         (ce_n),
		.we_n         (we_n),
		.oe_n         (oe_n),
		.addr         (flash_addr),
		.din          (dq_out),
		.reset_hv     (reset_hv),
		.a9_hv        (a9_hv),
		.oe_hv        (oe_hv),
		.stuck        (stuck),
		.win_closed   (win_closed),
		.dq           (dev_q),
		.ready_busy_n (ready_busy_n)
	);

	// Shared data wire: host wins while it drives
	assign dq_in = dq_oe ? dq_out : dev_q;

	always #2 clk_sys = ~clk_sys;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	// Program one operation, wait out busy, compare the status word
	task automatic run(input row_t r);
		int n;
		stuck <= r.stuck;
		win_closed <= r.win;
		apb(1'b1, REG_ADDR, {12'h000, r.a}, q, e);
		apb(1'b1, REG_WDATA, {24'h000000, r.d}, q, e);
		apb(1'b1, REG_CTRL, {22'h000000, r.hi, 5'h00, r.op}, q, e);
		n = 0;
		do
		begin
			apb(1'b0, REG_STATUS, 32'h00000000, q, e);
			n++;
		end while (q[ST_BUSY] !== 1'b0 && n < 400);
		check(q[ST_BUSY], 1'b0);
		check(q[ST_FAIL], r.fail);
		check(q[ST_OK], !(r.fail | r.rej));
		check(q[ST_REJECT], r.rej);
		if (r.chk[1]) check(q[ST_RB], r.rb);
		if (r.chk[0]) check(q[ST_RD_LSB +: 8], r.b);
	endtask

	// Watchdog and write-strobe width monitor
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 100000)
		begin
			failures++;
			end_sim();
		end
		if (we_n === 1'b0)
		begin
			wl++;
			check(oe_n, 1'b1);
		end
		else
		begin
			if (wl != 0 && wl != 20) check(wl, STROBE_CYC);
			wl = 0;
		end
	end

	initial
	begin
		clk_sys = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		stuck = 1'b0;
		win_closed = 1'b0;
		failures = 0;
		comparisons = 0;
		cycles = 0;
		wl = 0;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, REG_CTRL, 32'h00000000, q, e);
		check(q, 32'h00000000);
		apb(1'b0, 12'h010, 32'h00000000, q, e);
		check(e, 1'b1);
		check(q, 32'h00000000);
		foreach (rows[i]) run(rows[i]);
		// Window closes between the two checks of an added sector
		win_closed <= 1'b0;
		apb(1'b1, REG_ADDR, 32'h00020000, q, e);
		apb(1'b1, REG_CTRL, 32'h00000004, q, e);
		@(negedge we_n);
		@(posedge clk_sys);
		win_closed <= 1'b1;
		do apb(1'b0, REG_STATUS, 32'h00000000, q, e); while (q[ST_BUSY] !== 1'b0);
		check(q[ST_MAYBE], 1'b1);
		check(q[ST_OK], 1'b0);
		check(q[ST_REJECT], 1'b0);
		// Reset in mid-run: strobes idle, qualifiers and registers cleared
		apb(1'b1, REG_CTRL, 32'h00000100, q, e);
		check(reset_hv, 1'b1);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check({ce_n, we_n, oe_n, dq_oe, reset_hv, a9_hv, oe_hv}, 7'b1110000);
		rst <= 1'b0;
		@(posedge clk_sys);
		apb(1'b0, REG_CTRL, 32'h00000000, q, e);
		check(q, 32'h00000000);
		end_sim();
	end
endmodule
